// file: design/sdpp_consts.vh
`ifndef SDPP_CONSTS_VH
`define SDPP_CONSTS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define SDPP_MCLK_PERIOD_NS   10
`define SDPP_MEM_CLK_PERIOD_NS 160
`define SDPP_HALF_CYCLES \
	((`SDPP_MEM_CLK_PERIOD_NS / `SDPP_MCLK_PERIOD_NS) / 2)

// ****************************************************************
// Widths
// ****************************************************************
`define SDPP_ADDR_W  13
`define SDPP_DATA_W  32
`define SDPP_BANK_W  2
`define SDPP_CS_W    2
`define SDPP_MASK_W  4

// ****************************************************************
// Post-reset pin levels
// ****************************************************************
`define SDPP_ADDR_IDLE   13'h0000
`define SDPP_DQ_IDLE     32'hffffffff
`define SDPP_BANK_IDLE   2'h0
`define SDPP_CS_IDLE     2'h3
`define SDPP_STROBE_IDLE 3'h7
`define SDPP_CKE_IDLE    1'h1
`define SDPP_MASK_IDLE   4'h0

// ****************************************************************
// Buffer entry layout
// ****************************************************************
`define SDPP_E_DATA_LO   0
`define SDPP_E_MASK_LO   32
`define SDPP_E_ADDR_LO   36
`define SDPP_E_BANK_LO   49
`define SDPP_E_CKE       51
`define SDPP_E_STB_LO    52
`define SDPP_E_CS_LO     55
`define SDPP_E_DRIVE     57
`define SDPP_E_CAPTURE   58
`define SDPP_E_W         59

`endif

// file: design/sdpp_port.v
`include "sdpp_consts.vh"
`default_nettype none

// Operation
// - Power reset is cold reset low; system reset is cold high, warm low.
// - Post-reset state only with cold high, warm high and lock high.
// - During power or system reset every port output is disabled.
// - Address drives command location; rests all low after reset.
// - Data bus is two-way; device holds it high after reset.
// - Outputs launch on rising memory clock edge; clock rests low.
// - Bank select names the command's bank; rests low after reset.
// - Row, column, write strobes with chip select encode commands; rest high.
// - Active-low chip selects enable each SDRAM decoder; rest high.
// - Clock enable high activates SDRAM clock; rests high after reset.
// - Byte mask selects data bytes; rests all low after reset.
// - Names ending in _l are asserted at logic 0.
module sdpp_port #(
	parameter DEPTH  = 2,
	parameter HALF   = `SDPP_HALF_CYCLES
) (
	// Clock and reset
	input  wire                      mclk,
	input  wire                      reset_n,
	// Reset pins and lock
	input  wire                      cold_reset_l,
	input  wire                      warm_reset_l,
	input  wire                      pll_lock,
	// Command stream from the memory logic
	input  wire                      cmd_valid,
	output wire                      cmd_ready,
	input  wire [`SDPP_CS_W-1:0]     cmd_chip_sel_l,
	input  wire                      cmd_row_strobe_l,
	input  wire                      cmd_col_strobe_l,
	input  wire                      cmd_write_strobe_l,
	input  wire                      cmd_clk_en,
	input  wire [`SDPP_BANK_W-1:0]   cmd_bank,
	input  wire [`SDPP_ADDR_W-1:0]   cmd_addr,
	input  wire [`SDPP_MASK_W-1:0]   cmd_mask,
	input  wire [`SDPP_DATA_W-1:0]   cmd_wdata,
	input  wire                      cmd_drive_dq,
	input  wire                      cmd_capture,
	// Read data back to the memory logic
	output reg                       rd_valid_reg,
	output reg  [`SDPP_DATA_W-1:0]   rd_data_reg,
	// Port status
	output reg                       port_live_reg,
	// SDRAM pins
	output reg                       mem_clk_out_reg,
	output reg  [`SDPP_ADDR_W-1:0]   mem_row_col_addr_reg,
	output reg  [`SDPP_BANK_W-1:0]   mem_bank_sel_reg,
	output reg                       mem_row_strobe_l_reg,
	output reg                       mem_col_strobe_l_reg,
	output reg                       mem_write_strobe_l_reg,
	output reg  [`SDPP_CS_W-1:0]     mem_chip_sel_l_reg,
	output reg                       mem_clk_en_reg,
	output reg  [`SDPP_MASK_W-1:0]   mem_byte_mask_reg,
	output wire                      mem_ctl_oe,
	input  wire [`SDPP_DATA_W-1:0]   mem_dq_in,
	output reg  [`SDPP_DATA_W-1:0]   mem_dq_out_reg,
	output wire                      mem_dq_oe
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	reg  [2:0]                 rst_meta_reg;
	reg  [2:0]                 rst_sync_reg;
	reg  [`SDPP_DATA_W-1:0]    dq_meta_reg;
	reg  [`SDPP_DATA_W-1:0]    dq_sync_reg;

	always @(posedge mclk) begin
		if (!reset_n) begin
			rst_meta_reg <= 3'h0;
			rst_sync_reg <= 3'h0;
			dq_meta_reg  <= 32'h00000000;
			dq_sync_reg  <= 32'h00000000;
		end else begin
			rst_meta_reg <= {pll_lock, warm_reset_l, cold_reset_l};
			rst_sync_reg <= rst_meta_reg;
			dq_meta_reg  <= mem_dq_in;
			dq_sync_reg  <= dq_meta_reg;
		end
	end

	// ****************************************************************
	// Reset condition decode
	// ****************************************************************
	wire power_rst = !rst_sync_reg[0];
	wire sys_rst   = rst_sync_reg[0] && !rst_sync_reg[1];
	// The lock term keeps the port dark while the clock synthesiser
	// settles, even though neither reset is held any more.
	wire live_next = !power_rst && !sys_rst
			&& rst_sync_reg[2];

	always @(posedge mclk) begin
		if (!reset_n)
			port_live_reg <= 1'b0;
		else
			port_live_reg <= live_next;
	end

	assign mem_ctl_oe = port_live_reg;

	// ****************************************************************
	// Memory clock divider
	// ****************************************************************
	reg  [7:0] div_cnt_reg;
	wire       div_wrap = (div_cnt_reg == HALF - 1);
	wire       rise     = port_live_reg && div_wrap
			&& !mem_clk_out_reg;

	always @(posedge mclk) begin
		if (!reset_n || !port_live_reg) begin
			div_cnt_reg     <= 8'h00;
			mem_clk_out_reg <= 1'b0;
		end else if (div_wrap) begin
			div_cnt_reg     <= 8'h00;
			mem_clk_out_reg <= !mem_clk_out_reg;
		end else begin
			div_cnt_reg     <= div_cnt_reg + 8'h01;
		end
	end

	// ****************************************************************
	// Two-entry command buffer
	// ****************************************************************
	reg  [`SDPP_E_W-1:0] buf_mem [0:DEPTH-1];
	reg  [0:0]           wr_ptr_reg;
	reg  [0:0]           rd_ptr_reg;
	reg  [1:0]           count_reg;
	wire                 buf_full  = (count_reg == DEPTH);
	wire                 buf_empty = (count_reg == 2'h0);
	// Nothing is accepted until the port is live, so no command can
	// reach the pins before the post-reset state is reached.
	assign cmd_ready = port_live_reg && !buf_full;
	wire push = cmd_valid && cmd_ready;
	wire pop  = rise && !buf_empty;
	wire [`SDPP_E_W-1:0] push_word = {cmd_capture, cmd_drive_dq,
			cmd_chip_sel_l, cmd_row_strobe_l, cmd_col_strobe_l,
			cmd_write_strobe_l, cmd_clk_en, cmd_bank, cmd_addr,
			cmd_mask, cmd_wdata};
	wire [`SDPP_E_W-1:0] head = buf_mem[rd_ptr_reg];

	always @(posedge mclk) begin
		if (push)
			buf_mem[wr_ptr_reg] <= push_word;
	end

	always @(posedge mclk) begin
		if (!reset_n || !port_live_reg) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 2'h1;
			else if (pop && !push)
				count_reg <= count_reg - 2'h1;
		end
	end

	// ****************************************************************
	// Pin launch on the rising memory clock edge
	// ****************************************************************
	reg dq_drive_reg;
	assign mem_dq_oe = port_live_reg && dq_drive_reg;

	always @(posedge mclk) begin
		if (!reset_n || !port_live_reg) begin
			mem_row_col_addr_reg   <= `SDPP_ADDR_IDLE;
			mem_dq_out_reg         <= `SDPP_DQ_IDLE;
			dq_drive_reg           <= 1'b1;
			mem_bank_sel_reg       <= `SDPP_BANK_IDLE;
			{mem_row_strobe_l_reg, mem_col_strobe_l_reg,
				mem_write_strobe_l_reg} <= `SDPP_STROBE_IDLE;
			mem_chip_sel_l_reg     <= `SDPP_CS_IDLE;
			mem_clk_en_reg         <= `SDPP_CKE_IDLE;
			mem_byte_mask_reg      <= `SDPP_MASK_IDLE;
		end else if (pop) begin
			mem_row_col_addr_reg <= head[`SDPP_E_ADDR_LO +:
					`SDPP_ADDR_W];
			mem_bank_sel_reg     <= head[`SDPP_E_BANK_LO +:
					`SDPP_BANK_W];
			{mem_row_strobe_l_reg, mem_col_strobe_l_reg,
				mem_write_strobe_l_reg} <=
					head[`SDPP_E_STB_LO +: 3];
			mem_chip_sel_l_reg   <= head[`SDPP_E_CS_LO +:
					`SDPP_CS_W];
			mem_clk_en_reg       <= head[`SDPP_E_CKE];
			mem_byte_mask_reg    <= head[`SDPP_E_MASK_LO +:
					`SDPP_MASK_W];
			mem_dq_out_reg       <= head[`SDPP_E_DATA_LO +:
					`SDPP_DATA_W];
			dq_drive_reg         <= head[`SDPP_E_DRIVE];
		end else if (rise) begin
			// An empty slot is a deselect: both chips ignore the strobes.
			mem_chip_sel_l_reg   <= `SDPP_CS_IDLE;
			{mem_row_strobe_l_reg, mem_col_strobe_l_reg,
				mem_write_strobe_l_reg} <= `SDPP_STROBE_IDLE;
			mem_dq_out_reg       <= `SDPP_DQ_IDLE;
			dq_drive_reg         <= 1'b1;
		end
	end

	// ****************************************************************
	// Read capture
	// ****************************************************************
	// The SDRAM holds its word a whole memory clock, so the two-flop
	// delay of the synchroniser costs nothing at this clock ratio.
	always @(posedge mclk) begin
		if (!reset_n || !port_live_reg) begin
			rd_valid_reg <= 1'b0;
			rd_data_reg  <= 32'h00000000;
		end else begin
			rd_valid_reg <= pop && head[`SDPP_E_CAPTURE];
			if (pop && head[`SDPP_E_CAPTURE])
				rd_data_reg <= dq_sync_reg;
		end
	end

endmodule

`default_nettype wire

// file: verification/sdpp_port_props.sv
`default_nettype none
module sdpp_port_chk (
	// Clock, reset, reset pins and status
	input wire logic		mclk,
	input wire logic		reset_n,
	input wire logic		cold_reset_l,
	input wire logic		warm_reset_l,
	input wire logic		pll_lock,
	input wire logic		cmd_ready,
	input wire logic		port_live_reg,
	input wire logic		rd_valid_reg,
	// SDRAM pins
	input wire logic		mem_clk_out_reg,
	input wire logic [12:0]	mem_row_col_addr_reg,
	input wire logic [1:0]	mem_bank_sel_reg,
	input wire logic		mem_row_strobe_l_reg,
	input wire logic		mem_col_strobe_l_reg,
	input wire logic		mem_write_strobe_l_reg,
	input wire logic [1:0]	mem_chip_sel_l_reg,
	input wire logic		mem_clk_en_reg,
	input wire logic [3:0]	mem_byte_mask_reg,
	input wire logic		mem_ctl_oe,
	input wire logic		mem_dq_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	wire logic [24:0]	pins = {mem_row_col_addr_reg, mem_bank_sel_reg,
		mem_chip_sel_l_reg, mem_byte_mask_reg, mem_row_strobe_l_reg,
		mem_col_strobe_l_reg, mem_write_strobe_l_reg, mem_clk_en_reg};
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Three samples cover both synchroniser stages and the live flop.
	sequence s_low3(sig);
		!(sig) [*3];
	endsequence
	AST_RESET_OFF: assert property (
		s_low3(cold_reset_l && warm_reset_l && pll_lock) |=> !port_live_reg)
		else $error("port live while held in reset");
	AST_LIVE_UP: assert property (
		(cold_reset_l && warm_reset_l && pll_lock) [*4] |=> port_live_reg)
		else $error("port not live after reset released");
	AST_OE_OFF: assert property (
		!port_live_reg |-> !mem_ctl_oe && !mem_dq_oe)
		else $error("pins driven while not live");
	AST_NO_CMD: assert property (!port_live_reg |-> !cmd_ready)
		else $error("command taken before live");
	AST_IDLE: assert property (
		$rose(port_live_reg) |-> pins == {13'h0000, 2'h0, 2'h3, 4'h0, 4'hf})
		else $error("pins not at idle levels on going live");
	AST_CLK_DARK: assert property (
		!port_live_reg && !$past(port_live_reg) |-> !mem_clk_out_reg)
		else $error("memory clock not resting low");
	AST_LAUNCH: assert property (
		port_live_reg && $past(port_live_reg) && !$rose(mem_clk_out_reg)
		|-> $stable(pins)) else $error("pins changed off the clock rise");
	// The pulse is set by the same edge as the capturing rise, so the clock
	// has just gone high when the pulse is first seen.
	AST_RD: assert property (rd_valid_reg |-> mem_clk_out_reg &&
		!$past(mem_clk_out_reg) ##1 !rd_valid_reg)
		else $error("read pulse misplaced");
endmodule
bind sdpp_port sdpp_port_chk u_chk (.*);
`default_nettype wire

// file: verification/sdpp_sdram_model.sv
`default_nettype none
module sdpp_sdram_model (
	// Pins as the memory sees them
	input wire logic		clk,
	input wire logic		oe,
	input wire logic [1:0]	cs_l,
	input wire logic [2:0]	cmd,
	input wire logic [12:0]	addr,
	input wire logic [3:0]	mask,
	input wire logic [31:0]	dq,
	output var logic [31:0]	dq_drv
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0]	mem [16] = '{default: 32'h0};
	initial dq_drv = 32'h0;
	// Sampling mid-period avoids racing pins launched with the rise.
	always @(negedge clk) begin
		if (oe && !cs_l[0] && cmd == 3'h4)
			for (int b = 0; b < 4; b++)
				if (!mask[b])
					mem[addr[3:0]][8*b+:8] <= dq[8*b+:8];
		// Released data shows the inverse so a stale word never passes.
		dq_drv <= (oe && !cs_l[0] && cmd == 3'h5) ? mem[addr[3:0]] : ~dq_drv;
	end
endmodule
`default_nettype wire

// file: verification/sdpp_port_test.sv
`default_nettype none
module sdpp_port_test;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [12:0] a; logic [3:0] m; logic [31:0] d, e;}
		sdpp_row_t;
	logic	mclk, reset_n, cold_reset_l, warm_reset_l, pll_lock, cmd_valid;
	logic	cmd_row_strobe_l, cmd_col_strobe_l, cmd_write_strobe_l, cmd_ready;
	logic	cmd_drive_dq, cmd_capture, rd_valid_reg, port_live_reg, mem_ctl_oe;
	logic	mem_clk_out_reg, mem_row_strobe_l_reg, mem_col_strobe_l_reg;
	logic	mem_write_strobe_l_reg, mem_clk_en_reg, mem_dq_oe;
	logic	cmd_clk_en = 1'b1;
	logic [1:0]	cmd_bank = 2'h1;
	logic [1:0]	cmd_chip_sel_l, mem_bank_sel_reg, mem_chip_sel_l_reg;
	logic [3:0]	cmd_mask, mem_byte_mask_reg;
	logic [12:0]	cmd_addr, mem_row_col_addr_reg;
	logic [31:0]	cmd_wdata, rd_data_reg, mem_dq_out_reg, mem_dq_in, mdl_dq;
	logic [2:0]	st;
	logic [56:0]	pins;
	int	n_fail = 0;
	int	samples_checked = 0;
	localparam logic [56:0] idle_pins = {19'h0, 32'hffff_ffff, 6'h3f};
	sdpp_row_t	rows [4] = '{'{13'h0001, 4'h0, 32'h89ab_cdef, 32'h89ab_cdef},
		'{13'h0002, 4'h1, 32'h1234_5678, 32'h1234_5600},
		'{13'h000f, 4'ha, 32'hffff_ffff, 32'h00ff_00ff},
		'{13'h1ff4, 4'hf, 32'h5555_aaaa, 32'h0000_0000}};
	logic [2:0]	pats [3] = '{3'h5, 3'h6, 3'h3};
	sdpp_port uut (.*);
	sdpp_sdram_model mdl (.clk(mem_clk_out_reg), .oe(mem_ctl_oe),
		.cs_l(mem_chip_sel_l_reg), .addr(mem_row_col_addr_reg),
		.cmd({mem_row_strobe_l_reg, mem_col_strobe_l_reg,
		mem_write_strobe_l_reg}), .mask(mem_byte_mask_reg),
		.dq(mem_dq_in), .dq_drv(mdl_dq));
	assign mem_dq_in = mem_dq_oe ? mem_dq_out_reg : mdl_dq;
	assign st = {cmd_ready, rd_valid_reg, port_live_reg};
	assign pins = {mem_row_col_addr_reg, mem_bank_sel_reg, mem_byte_mask_reg,
		mem_dq_out_reg, mem_row_strobe_l_reg, mem_col_strobe_l_reg,
		mem_write_strobe_l_reg, mem_chip_sel_l_reg, mem_clk_en_reg};
	task automatic give_verdict();
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wt(input int k);
		int i;
		for (i = 0; i < 200 && st[k] !== 1'b1; i++)
			@(negedge mclk);
		if (i == 200) begin
			chk(64'h0, 64'h1);
			give_verdict();
		end
	endtask
	// Fields are held from the falling edge until the rise that takes them.
	task automatic send(input logic [2:0] s, input logic [12:0] a,
			input logic [3:0] m, input logic [31:0] d, input logic [1:0] x);
		cmd_valid = 1'b1;
		cmd_chip_sel_l = (s == 3'h7) ? 2'h3 : 2'h2;
		{cmd_row_strobe_l, cmd_col_strobe_l, cmd_write_strobe_l} = s;
		{cmd_addr, cmd_mask, cmd_wdata, cmd_drive_dq, cmd_capture} = {a, m, d, x};
		wt(2);
		@(negedge mclk);
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		{reset_n, cold_reset_l, warm_reset_l, pll_lock, cmd_valid} = 5'h06;
		{cmd_chip_sel_l, cmd_row_strobe_l, cmd_col_strobe_l, cmd_write_strobe_l,
			cmd_addr, cmd_mask, cmd_wdata, cmd_drive_dq, cmd_capture} = '1;
		repeat (10) @(negedge mclk);
		reset_n = 1'b1;
		{cold_reset_l, warm_reset_l, pll_lock} = 3'h7;
		wt(0);
		chk(pins, idle_pins);
		foreach (rows[k]) begin
			send(3'h3, rows[k].a, 4'h0, 32'h0, 2'h0);
			send(3'h4, rows[k].a, rows[k].m, rows[k].d, 2'h2);
			send(3'h5, rows[k].a, 4'h0, 32'h0, 2'h0);
			send(3'h7, rows[k].a, 4'h0, 32'h0, 2'h1);
			cmd_valid = 1'b0;
			wt(1);
			chk(rd_data_reg, rows[k].e);
			chk({mem_row_col_addr_reg, mem_bank_sel_reg, mem_byte_mask_reg, mem_clk_en_reg, mem_chip_sel_l_reg}, {rows[k].a, 2'h1, 4'h0, 1'b1, 2'h3});
		end
		// One slot pops per memory clock, so three quick offers fill it.
		repeat (3) send(3'h7, 13'h0, 4'h0, 32'h0, 2'h0);
		chk({cmd_ready, mem_chip_sel_l_reg}, 3'h3);
		cmd_valid = 1'b0;
		foreach (pats[k]) begin
			{cold_reset_l, warm_reset_l, pll_lock} = pats[k];
			repeat (4) @(negedge mclk);
			chk({port_live_reg, mem_ctl_oe, mem_dq_oe, cmd_ready}, 4'h0);
			{cold_reset_l, warm_reset_l, pll_lock} = 3'h7;
			wt(0);
			chk(pins, idle_pins);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
